// ---- design/at_glue.sv ----
// memory strobe timing, refresh, decode and transceiver control of the system controller
`default_nettype none
module at_glue
  import at_glue_pkg::*;
(
  // clock and reset
  input  wire logic                   ref_clk_i,
  input  wire logic                   rst_n_i,
  // processor status and cycle end
  input  wire logic                   proc_status_zero_n_i,
  input  wire logic                   proc_status_one_n_i,
  input  wire logic                   mem_cycle_i,
  input  wire logic                   bus_cycle_end_i,
  input  wire logic                   byte_high_en_n_i,
  input  wire logic                   sys_addr0_i,
  // arbitration and dma
  input  wire logic                   hold_ack_i,
  input  wire logic                   bus_master_req_n_i,
  input  wire logic                   dma_addr_en_a_n_i,
  input  wire logic                   dma_addr_en_b_n_i,
  // memory selects and refresh
  input  wire logic                   wide_mem_sel_n_i,
  input  wire logic                   low_meg_sel_n_i,
  input  wire logic                   refresh_req_n_i,
  input  wire logic                   ram_write_wait_sel_i,
  input  wire logic                   mem_read_cmd_n_i,
  input  wire logic                   mem_write_cmd_n_i,
  // peripheral address
  input  wire logic [PADDR_W-1:PADDR_LSB] periph_addr_bus_i,
  // dram timing
  output logic                        ras_timing_o,
  output logic                        cas_timing_o,
  output logic                        early_ram_write_n_o,
  output logic                        refresh_counter_clock_n_o,
  // bus glue
  output logic                        rtc_strobe_enable_n_o,
  output logic                        second_phase_flag_o,
  output logic                        xbus_xcvr_dir_o,
  output logic                        byte_swap_xcvr_dir_o,
  output logic                        byte_swap_xcvr_gate_o,
  output logic                        low_byte_latch_ctl_o,
  output logic                        periph_iface_sel_n_o,
  output logic                        dma_addr_en_out_n_o,
  output logic                        periph_byte_high_en_n_o,
  output logic                        modulator_disable_o,
  // low megabyte expansion strobes
  output logic                        low_meg_mem_read_n_o,
  output logic                        low_meg_mem_write_n_o,
  output logic                        low_meg_strobe_oe_o
);
  import at_glue_pkg::*;

  // =====================================================================
  // helpers
  function automatic logic in_periph_win(input logic [PADDR_W-1:PADDR_LSB] a);
    logic [9:0] full;
    full = {a, PADDR_LSB'(0)};
    return (full >= PERIPH_LO) && (full <= PERIPH_HI);
  endfunction

  cyc_state_t state_r;
  cyc_state_t state_nxt;
  logic       cyc_write_r;
  logic       cyc_mem_r;
  logic       cyc_start;
  logic       cyc_end;
  logic       refresh_d_r;
  logic       refresh_start;
  logic       refresh_end;
  logic       dma_active;
  logic       narrow_swap;
  logic       timer_start;
  logic       timer_end;

  assign cyc_start     = !proc_status_zero_n_i || !proc_status_one_n_i;
  assign cyc_end       = (state_r == CYC_TC) && bus_cycle_end_i;
  assign refresh_start = refresh_d_r && !refresh_req_n_i;
  assign refresh_end   = !refresh_d_r && refresh_req_n_i;
  assign dma_active    = !dma_addr_en_a_n_i || !dma_addr_en_b_n_i;
  // odd byte on an 8-bit target needs the swap path; a 16-bit target never does
  assign narrow_swap   = wide_mem_sel_n_i && !byte_high_en_n_i && sys_addr0_i;

  // =====================================================================
  // bus cycle tracker
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      CYC_IDLE: if (cyc_start) state_nxt = CYC_TS1;
      CYC_TS1:  state_nxt = CYC_TS2;
      CYC_TS2:  state_nxt = CYC_TC;
      CYC_TC:   if (bus_cycle_end_i) state_nxt = CYC_IDLE;
      default:  state_nxt = CYC_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
      state_r <= CYC_IDLE;
    else
      state_r <= state_nxt;
  end

  // cycle type caught at the status phase; write is status-zero alone
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      cyc_write_r <= 1'b0;
      cyc_mem_r   <= 1'b0;
    end
    else if (state_r == CYC_IDLE && cyc_start)
    begin
      cyc_write_r <= !proc_status_zero_n_i && proc_status_one_n_i;
      cyc_mem_r   <= mem_cycle_i;
    end
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
      second_phase_flag_o <= 1'b0;
    else
      second_phase_flag_o <= (state_nxt == CYC_TS2);
  end

  // =====================================================================
  // dram strobes and refresh
  assign timer_start = (state_r == CYC_TS1 && cyc_mem_r) ||
                       (state_r == CYC_IDLE && refresh_start);
  assign timer_end   = cyc_end || refresh_end;

  dram_strobe_timer u_timer (
    .ref_clk_i   (ref_clk_i),
    .rst_n_i     (rst_n_i),
    .start_i     (timer_start),
    .one_wait_i  (cyc_write_r && ram_write_wait_sel_i && !refresh_start),
    .cycle_end_i (timer_end),
    .ras_o       (ras_timing_o),
    .cas_o       (cas_timing_o)
  );

  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
      early_ram_write_n_o <= RAMW_RST;
    else if (state_r == CYC_TS1 && cyc_mem_r && cyc_write_r)
      early_ram_write_n_o <= 1'b0;
    else if (cyc_end)
      early_ram_write_n_o <= 1'b1;
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      refresh_d_r               <= 1'b1;
      refresh_counter_clock_n_o <= 1'b1;
    end
    else
    begin
      refresh_d_r               <= refresh_req_n_i;
      refresh_counter_clock_n_o <= refresh_req_n_i;
    end
  end

  // =====================================================================
  // real time clock strobe enable, sticky after the first status-zero
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
      rtc_strobe_enable_n_o <= RTC_EN_RST;
    else if (!proc_status_zero_n_i)
      rtc_strobe_enable_n_o <= 1'b0;
  end

  // =====================================================================
  // transceivers and byte conversion
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      xbus_xcvr_dir_o       <= 1'b0;
      byte_swap_xcvr_dir_o  <= 1'b0;
      byte_swap_xcvr_gate_o <= 1'b0;
      low_byte_latch_ctl_o  <= 1'b0;
    end
    else
    begin
      // processor writes flow S to X; reads and foreign masters flow X to S
      xbus_xcvr_dir_o       <= !hold_ack_i && cyc_write_r && state_nxt != CYC_IDLE;
      byte_swap_xcvr_dir_o  <= cyc_write_r;
      byte_swap_xcvr_gate_o <= narrow_swap && state_nxt == CYC_TC;
      low_byte_latch_ctl_o  <= narrow_swap && cyc_write_r && state_nxt == CYC_TC;
    end
  end

  // =====================================================================
  // peripheral decode, dma and expansion strobes
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      periph_iface_sel_n_o    <= 1'b1;
      dma_addr_en_out_n_o     <= 1'b1;
      periph_byte_high_en_n_o <= 1'b1;
      modulator_disable_o     <= 1'b0;
    end
    else
    begin
      periph_iface_sel_n_o    <= !(in_periph_win(periph_addr_bus_i) &&
                                   (!hold_ack_i || !bus_master_req_n_i));
      dma_addr_en_out_n_o     <= !dma_active;
      // during dma the odd address alone marks the high byte
      periph_byte_high_en_n_o <= dma_active ? !sys_addr0_i : byte_high_en_n_i;
      modulator_disable_o     <= dma_active;
    end
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      low_meg_mem_read_n_o  <= 1'b1;
      low_meg_mem_write_n_o <= 1'b1;
      low_meg_strobe_oe_o   <= 1'b0;
    end
    else
    begin
      low_meg_mem_read_n_o  <= mem_read_cmd_n_i;
      low_meg_mem_write_n_o <= mem_write_cmd_n_i;
      low_meg_strobe_oe_o   <= !low_meg_sel_n_i;
    end
  end

  // =====================================================================
  // checks
  rtc_first_s0_a : assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    !proc_status_zero_n_i |=> !rtc_strobe_enable_n_o)
    else $error("rtc enable not low after status zero");
  rtc_sticky_a : assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    !rtc_strobe_enable_n_o |=> !rtc_strobe_enable_n_o)
    else $error("rtc enable returned high");
  phase_two_a : assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    state_r == CYC_IDLE && cyc_start |=> ##1 second_phase_flag_o ##1 !second_phase_flag_o)
    else $error("second phase flag misplaced");
  ras_rise_a : assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    state_r == CYC_TS1 && cyc_mem_r |=> ras_timing_o && second_phase_flag_o)
    else $error("row strobe missing in second phase");
  cas_end_a : assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    cyc_end |=> !cas_timing_o && early_ram_write_n_o)
    else $error("strobes not released at cycle end");
  early_ram_write_n_low_a : assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    state_r == CYC_TS1 && cyc_mem_r && cyc_write_r |=> !early_ram_write_n_o)
    else $error("early write not asserted");
  periph_sel_a : assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    !periph_iface_sel_n_o |-> $past(in_periph_win(periph_addr_bus_i))
      && ($past(!hold_ack_i) || $past(!bus_master_req_n_i)))
    else $error("peripheral select outside window or ownership");
  dma_out_a : assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    dma_active |=> !dma_addr_en_out_n_o && modulator_disable_o)
    else $error("dma enable output not low");
  lmeg_oe_a : assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    low_meg_strobe_oe_o |-> $past(!low_meg_sel_n_i))
    else $error("low megabyte drivers enabled without select");
  refresh_ras_a : assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    state_r == CYC_IDLE && refresh_start |=> ras_timing_o && !refresh_counter_clock_n_o)
    else $error("refresh did not start");

  mem_write_c : cover property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    !early_ram_write_n_o && cas_timing_o);
  refresh_c   : cover property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    state_r == CYC_IDLE && refresh_start);
  periph_c    : cover property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    !periph_iface_sel_n_o);
  swap_c      : cover property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    low_byte_latch_ctl_o);
endmodule : at_glue
`default_nettype wire

// ---- inc/at_glue_pkg.sv ----
// shared constants and types for the memory timing and bus glue block
`default_nettype none
package at_glue_pkg;
  // one processor clock is two phases of ref_clk_i
  localparam int unsigned PHASES_PER_CLK   = 2;
  // row strobe length in processor clocks, then in phases
  localparam int unsigned RAS_ZW_CLKS      = 2;
  localparam int unsigned RAS_OW_CLKS      = 3;
  localparam int unsigned RAS_ZW_PH        = RAS_ZW_CLKS * PHASES_PER_CLK;
  localparam int unsigned RAS_OW_PH        = RAS_OW_CLKS * PHASES_PER_CLK;
  // column strobe delay after row strobe, in phases (one clock, one and a half clocks)
  localparam int unsigned CAS_ZW_PH        = PHASES_PER_CLK;
  localparam int unsigned CAS_OW_PH        = PHASES_PER_CLK + PHASES_PER_CLK / 2;
  localparam int unsigned PH_CNT_W         = 3;
  // peripheral interface decode window
  localparam int unsigned PADDR_W          = 10;
  localparam int unsigned PADDR_LSB        = 5;
  localparam logic [9:0]  PERIPH_LO        = 10'h060;
  localparam logic [9:0]  PERIPH_HI        = 10'h09F;
  localparam logic        RTC_EN_RST       = 1'b1;
  localparam logic        RAMW_RST         = 1'b1;

  // gray coded bus cycle phases: idle, status phase 1, status phase 2, command
  typedef enum logic [1:0] {
    CYC_IDLE = 2'b00,
    CYC_TS1  = 2'b01,
    CYC_TS2  = 2'b11,
    CYC_TC   = 2'b10
  } cyc_state_t;
endpackage : at_glue_pkg
`default_nettype wire

// ---- design/dram_strobe_timer.sv ----
// row and column strobe timer for one on-board memory or refresh cycle
`default_nettype none
module dram_strobe_timer
  import at_glue_pkg::*;
(
  // clock and reset
  input  wire logic ref_clk_i,
  input  wire logic rst_n_i,
  // cycle control
  input  wire logic start_i,
  input  wire logic one_wait_i,
  input  wire logic cycle_end_i,
  // strobes
  output logic      ras_o,
  output logic      cas_o
);
  import at_glue_pkg::*;

  logic                ras_r;
  logic                cas_r;
  logic                wait_r;
  logic                armed_r;
  logic [PH_CNT_W-1:0] cnt_r;
  logic [PH_CNT_W-1:0] ras_last;
  logic [PH_CNT_W-1:0] cas_last;

  assign ras_last = wait_r ? PH_CNT_W'(RAS_OW_PH - 1) : PH_CNT_W'(RAS_ZW_PH - 1);
  assign cas_last = wait_r ? PH_CNT_W'(CAS_OW_PH - 1) : PH_CNT_W'(CAS_ZW_PH - 1);
  assign ras_o    = ras_r;
  assign cas_o    = cas_r;

  // =====================================================================
  // phase counter
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      cnt_r   <= '0;
      wait_r  <= 1'b0;
      armed_r <= 1'b0;
    end
    else if (start_i)
    begin
      cnt_r   <= '0;
      wait_r  <= one_wait_i;
      armed_r <= 1'b1;
    end
    else if (cycle_end_i)
      armed_r <= 1'b0;
    else if (armed_r && cnt_r != ras_last)
      cnt_r <= cnt_r + PH_CNT_W'(1);
  end

  // =====================================================================
  // row strobe
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
      ras_r <= 1'b0;
    else if (start_i)
      ras_r <= 1'b1;
    else if (ras_r && cnt_r == ras_last)
      ras_r <= 1'b0;
  end

  // =====================================================================
  // column strobe; the cycle end wins so a short cycle never leaves it high
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
      cas_r <= 1'b0;
    else if (cycle_end_i || start_i)
      cas_r <= 1'b0;
    else if (armed_r && cnt_r == cas_last)
      cas_r <= 1'b1;
  end

  // =====================================================================
  // checks
  ras_zero_len_a : assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    $rose(ras_r) && !wait_r && !start_i |-> ras_r[*4] ##1 !ras_r)
    else $error("row strobe zero-wait length wrong");
  ras_one_len_a : assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    $rose(ras_r) && wait_r && !start_i |-> ras_r[*6] ##1 !ras_r)
    else $error("row strobe one-wait length wrong");
  cas_zero_dly_a : assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    $rose(ras_r) && !wait_r |-> (!cas_r && !cycle_end_i && !start_i) ##1
      (!cycle_end_i && !start_i) |=> cas_r)
    else $error("column strobe zero-wait delay wrong");
  cas_one_dly_a : assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    $rose(cas_r) && wait_r |-> $past(ras_r, 3) && !$past(ras_r, 4))
    else $error("column strobe one-wait delay wrong");
endmodule : dram_strobe_timer
`default_nettype wire

// ---- dv/cpu_model.sv ----
// processor side model that issues status cycles into the glue block
`default_nettype none
module cpu_model
(
  // clock and reset
  input  wire logic ref_clk_i,
  input  wire logic rst_n_i,
  // request from the bench
  input  wire logic go_i,
  input  wire logic write_i,
  // processor status and cycle control
  output logic      status_zero_n_o,
  output logic      status_one_n_o,
  output logic      mem_cycle_o,
  output logic      cycle_end_o,
  output logic      busy_o
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [3:0] ph_r;

  // ==========================================================
  // sequencer: status held one processor clock, end pulse in cycle 9
  // a write is status zero alone, a read status one alone
  always @(negedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      ph_r            <= 4'h0;
      status_zero_n_o <= 1'b1;
      status_one_n_o  <= 1'b1;
      mem_cycle_o     <= 1'b0;
      cycle_end_o     <= 1'b0;
      busy_o          <= 1'b0;
    end
    else if (ph_r == 4'h0)
    begin
      busy_o          <= go_i;
      ph_r            <= {3'h0, go_i};
      status_zero_n_o <= ~(go_i & write_i);
      status_one_n_o  <= ~(go_i & ~write_i);
      mem_cycle_o     <= go_i;
    end
    else
    begin
      status_zero_n_o <= status_zero_n_o | (ph_r >= 4'h2);
      status_one_n_o  <= status_one_n_o | (ph_r >= 4'h2);
      // end comes only once the command phase is running
      cycle_end_o     <= (ph_r == 4'h9);
      mem_cycle_o     <= (ph_r != 4'hD);
      busy_o          <= (ph_r != 4'hD);
      ph_r            <= (ph_r == 4'hD) ? 4'h0 : ph_r + 4'h1;
    end
  end
endmodule // cpu_model
`default_nettype wire

// ---- dv/tb.sv ----
// self-checking bench for the memory timing and bus glue block
`default_nettype none
module tb;
  import at_glue_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  // ras_len, cas_on, cas_off, flag, early_ram_write_n_n, rclk_n, xdir, gate, latch
  typedef struct packed {
    logic [3:0] ras_len;
    logic [3:0] cas_on;
    logic [3:0] cas_off;
    logic [5:0] lv;
  } strobe_t;

  logic ref_clk_i, rst_n_i, proc_status_zero_n_i, proc_status_one_n_i, mem_cycle_i;
  logic bus_cycle_end_i, byte_high_en_n_i, sys_addr0_i, hold_ack_i, bus_master_req_n_i;
  logic dma_addr_en_a_n_i, dma_addr_en_b_n_i, wide_mem_sel_n_i, low_meg_sel_n_i;
  logic refresh_req_n_i, ram_write_wait_sel_i, mem_read_cmd_n_i, mem_write_cmd_n_i;
  logic [PADDR_W-1:PADDR_LSB] periph_addr_bus_i;
  logic ras_timing_o, cas_timing_o, early_ram_write_n_o, refresh_counter_clock_n_o;
  logic rtc_strobe_enable_n_o, second_phase_flag_o, xbus_xcvr_dir_o, byte_swap_xcvr_dir_o;
  logic byte_swap_xcvr_gate_o, low_byte_latch_ctl_o, periph_iface_sel_n_o;
  logic dma_addr_en_out_n_o, periph_byte_high_en_n_o, modulator_disable_o;
  logic low_meg_mem_read_n_o, low_meg_mem_write_n_o, low_meg_strobe_oe_o;
  logic go, wr, busy, ras_q, cas_q, act;
  int error_cnt, num_checks, cnt, cyc;
  strobe_t s;
  strobe_t sq[$];
  logic [13:0] dq[$];

  at_glue at_glue_i (.ref_clk_i, .rst_n_i, .proc_status_zero_n_i, .proc_status_one_n_i,
    .mem_cycle_i, .bus_cycle_end_i, .byte_high_en_n_i, .sys_addr0_i, .hold_ack_i,
    .bus_master_req_n_i, .dma_addr_en_a_n_i, .dma_addr_en_b_n_i, .wide_mem_sel_n_i,
    .low_meg_sel_n_i, .refresh_req_n_i, .ram_write_wait_sel_i, .mem_read_cmd_n_i,
    .mem_write_cmd_n_i, .periph_addr_bus_i, .ras_timing_o, .cas_timing_o,
    .early_ram_write_n_o, .refresh_counter_clock_n_o, .rtc_strobe_enable_n_o,
    .second_phase_flag_o, .xbus_xcvr_dir_o, .byte_swap_xcvr_dir_o, .byte_swap_xcvr_gate_o,
    .low_byte_latch_ctl_o, .periph_iface_sel_n_o, .dma_addr_en_out_n_o,
    .periph_byte_high_en_n_o, .modulator_disable_o, .low_meg_mem_read_n_o,
    .low_meg_mem_write_n_o, .low_meg_strobe_oe_o);

  cpu_model cpu_model_i (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .go_i(go), .write_i(wr),
    .status_zero_n_o(proc_status_zero_n_i), .status_one_n_o(proc_status_one_n_i),
    .mem_cycle_o(mem_cycle_i), .cycle_end_o(bus_cycle_end_i), .busy_o(busy));

  // ==========================================================
  // compare and report
  task automatic finish_test();
    $display("Checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic check_strobe(strobe_t e, strobe_t o);
    num_checks++;
    if (o !== e)
    begin
      error_cnt++;
      $display("Error strobe timing expected %h seen %h", e, o);
    end
  endtask

  task automatic check_decode(logic [13:0] em, logic [6:0] o);
    num_checks++;
    if ((o & em[6:0]) !== (em[13:7] & em[6:0]))
    begin
      error_cnt++;
      $display("Error decode outputs expected %h seen %h", em[13:7] & em[6:0], o & em[6:0]);
    end
  endtask

  task automatic check_bit(string name, logic e, logic o);
    num_checks++;
    if (o !== e)
    begin
      error_cnt++;
      $display("Error %s expected %b seen %b", name, e, o);
    end
  endtask

  // ==========================================================
  // watchers: oldest note is taken when a result shows
  always @(negedge ref_clk_i)
  begin
    if (dq.size() > 0)
      check_decode(dq.pop_front(), {periph_iface_sel_n_o, dma_addr_en_out_n_o,
        periph_byte_high_en_n_o, modulator_disable_o, low_meg_strobe_oe_o,
        low_meg_mem_read_n_o, low_meg_mem_write_n_o});
    if (ras_timing_o === 1'b1 && ras_q !== 1'b1)
    begin
      act = 1'b1;
      cnt = 0;
      s = '0;
      s.lv[5:2] = {second_phase_flag_o, early_ram_write_n_o, refresh_counter_clock_n_o,
                   xbus_xcvr_dir_o};
    end
    if (act)
    begin
      if (ras_timing_o === 1'b1)
        s.ras_len = s.ras_len + 4'h1;
      if (cas_timing_o === 1'b1 && cas_q !== 1'b1)
        s.cas_on = cnt[3:0];
      s.lv[1:0] = s.lv[1:0] | {byte_swap_xcvr_gate_o, low_byte_latch_ctl_o};
      if (cas_timing_o !== 1'b1 && cas_q === 1'b1)
      begin
        s.cas_off = cnt[3:0];
        act = 1'b0;
        check_strobe(sq.pop_front(), s);
      end
      cnt++;
    end
    ras_q = ras_timing_o;
    cas_q = cas_timing_o;
  end

  // run length guard, tests need a few hundred cycles
  always @(posedge ref_clk_i)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      error_cnt++;
      finish_test();
    end
  end

  // ==========================================================
  // stimulus
  task automatic do_reset();
    rst_n_i <= 1'b0;
    repeat (20) @(negedge ref_clk_i);
    rst_n_i <= 1'b1;
    @(negedge ref_clk_i);
    check_bit("rtc_strobe_enable_n_o", 1'b1, rtc_strobe_enable_n_o);
  endtask

  task automatic run_cycle(logic [2:0] c, strobe_t e);
    @(negedge ref_clk_i);
    ram_write_wait_sel_i <= c[1];
    wide_mem_sel_n_i     <= c[0];
    byte_high_en_n_i     <= ~c[0];
    sys_addr0_i          <= c[0];
    wr                   <= c[2];
    go                   <= 1'b1;
    sq.push_back(e);
    @(negedge ref_clk_i);
    go <= 1'b0;
    repeat (20)
    begin
      @(negedge ref_clk_i);
      if (!busy)
        break;
    end
    check_bit("early_ram_write_n_o", 1'b1, early_ram_write_n_o);
    check_bit("rtc_strobe_enable_n_o", 1'b0, rtc_strobe_enable_n_o);
    check_bit("byte_swap_xcvr_dir_o", c[2], byte_swap_xcvr_dir_o);
  endtask

  // write zero-wait wide, write one-wait narrow, read with wait select narrow
  logic [2:0] ctl [3] = '{3'b100, 3'b111, 3'b011};
  strobe_t    exp [3] = '{'{4'h4, 4'h2, 4'h8, 6'h2C}, '{4'h6, 4'h3, 4'h8, 6'h2F},
                          '{4'h4, 4'h2, 4'h8, 6'h3A}};

  initial
  begin
    ref_clk_i = 1'b0;
    forever #2.5 ref_clk_i = ~ref_clk_i;
  end

  initial
  begin
    logic [31:0] r;
    logic [4:0]  a;
    logic        dma;
    {rst_n_i, go, wr, hold_ack_i, byte_high_en_n_i, sys_addr0_i} = 6'h02;
    {bus_master_req_n_i, dma_addr_en_a_n_i, dma_addr_en_b_n_i, low_meg_sel_n_i} = 4'hF;
    {refresh_req_n_i, mem_read_cmd_n_i, mem_write_cmd_n_i} = 3'h7;
    {wide_mem_sel_n_i, ram_write_wait_sel_i, periph_addr_bus_i} = 7'h00;
    {ras_q, cas_q, act} = 3'h0;
    r = $urandom(32'h7C14F081);
    do_reset();
    repeat (200)
    begin
      @(negedge ref_clk_i);
      r   = $urandom;
      a   = r[8] ? 5'h02 + {3'h0, r[10:9]} : r[14:10];
      dma = ~(r[2] & r[3]);
      hold_ack_i         <= r[0];
      bus_master_req_n_i <= r[1];
      dma_addr_en_a_n_i  <= r[2];
      dma_addr_en_b_n_i  <= r[3];
      low_meg_sel_n_i    <= r[4];
      mem_read_cmd_n_i   <= r[5];
      mem_write_cmd_n_i  <= r[6];
      sys_addr0_i        <= r[7];
      periph_addr_bus_i  <= a;
      @(posedge ref_clk_i);
      dq.push_back({~({a, 5'h00} >= PERIPH_LO && {a, 5'h1F} <= PERIPH_HI && !(r[0] & r[1])),
                    ~dma, ~r[7], dma, ~r[4], r[5], r[6], 2'h3, dma, 4'hF});
    end
    @(negedge ref_clk_i);
    {hold_ack_i, bus_master_req_n_i, dma_addr_en_a_n_i, dma_addr_en_b_n_i} <= 4'h7;
    {low_meg_sel_n_i, mem_read_cmd_n_i, mem_write_cmd_n_i} <= 3'h7;
    for (int i = 0; i < 3; i++)
      run_cycle(ctl[i], exp[i]);
    @(negedge ref_clk_i);
    refresh_req_n_i <= 1'b0;
    sq.push_back('{4'h4, 4'h2, 4'h8, 6'h10});
    repeat (8) @(negedge ref_clk_i);
    refresh_req_n_i <= 1'b1;
    repeat (6) @(negedge ref_clk_i);
    do_reset();
    run_cycle(ctl[0], exp[0]);
    repeat (4) @(negedge ref_clk_i);
    finish_test();
  end
endmodule // tb
`default_nettype wire
